// file: rtl/ubc_pkg.sv
// Constants and types of the buffer byte counter of one DMA channel
// Assumes one clock (AHB clock) and an active-low asynchronous reset
package ubc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] UBC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] UBC_OFS_LENGTH = 8'h04;
  localparam logic [7:0] UBC_OFS_ADDR   = 8'h08;
  localparam logic [7:0] UBC_OFS_STATUS = 8'h0c;
  localparam logic [7:0] UBC_OFS_RXLEN  = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UBC_CTRL_START  = 0;
  localparam int UBC_CTRL_STOP   = 1;
  localparam int UBC_CTRL_RESUME = 2;
  localparam int UBC_STAT_ACTIVE = 24;

  // ----------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------
  localparam int          UBC_CNT_W      = 17;
  localparam logic [16:0] UBC_FULL_LEN   = 17'h10000;
  localparam logic [2:0]  UBC_WORD_BYTES = 3'h4;
  localparam logic [2:0]  UBC_HALF_BYTES = 3'h2;
  localparam logic [2:0]  UBC_BYTE_BYTES = 3'h1;
  localparam logic [15:0] UBC_LEN_RST    = 16'h0000;
  localparam logic [31:0] UBC_ADDR_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UBC_ST_IDLE = 2'b01,
    UBC_ST_RUN  = 2'b10
  } ubc_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ubc_bus_t;

  typedef struct packed {
    ubc_state_t           st;
    logic                 stop;
    logic [15:0]          len;
    logic [31:0]          addr;
    logic [UBC_CNT_W-1:0] cnt;
    logic [31:0]          rdata;
  } ubc_regs_t;

endpackage : ubc_pkg

// file: rtl/ubc_width.sv
// Byte width of the next AHB access of the channel
// Assumes the remaining count and the current address come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module ubc_width
  import ubc_pkg::*;
(
  // Current position
  input  wire logic [1:0]           addr_lo,
  input  wire logic [UBC_CNT_W-1:0] cnt,
  // Access width
  output logic      [2:0]           bytes
);

  always_comb begin
    if (addr_lo == 2'h0 && cnt >= 17'h00004) begin
      bytes = UBC_WORD_BYTES;
    end else if (addr_lo[0] == 1'b0 && cnt >= 17'h00002) begin
      bytes = UBC_HALF_BYTES;
    end else begin
      bytes = UBC_BYTE_BYTES;
    end
  end

endmodule : ubc_width
`default_nettype wire

// file: rtl/ubc_counter.sv
// Remaining byte counter and access sequencer of one DMA channel
// Assumes a plain register port and an AHB master that acks address phases
//
// How it works
// - The count register always holds the bytes of the buffer still to move.
// - Each acknowledged address phase subtracts its byte width from the count.
// - Accesses move 4 bytes, narrower only at an unaligned start or end.
// - The last access covers exactly the bytes left and never more.
// - With a zero programmed length the received bytes are 0x10000 minus the count.
`timescale 1ns/1ps
`default_nettype none
module ubc_counter
  import ubc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire ubc_bus_t    bus,
  output logic      [31:0] rdata,
  // AHB access sequencing
  output logic             dma_req,
  output logic      [31:0] dma_addr,
  output logic      [2:0]  dma_bytes,
  input  wire logic        dma_ack,
  // Channel state
  output logic             channel_active_flag,
  output logic      [16:0] remaining_byte_count
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ubc_regs_t            cur_ff;
  ubc_regs_t            nxt_cur;
  logic [2:0]           bytes_w;
  logic [UBC_CNT_W-1:0] rx_len_w;
  logic                 take_w;
  logic                 wr_ctrl_w;

  ubc_width u_width (
    .addr_lo (cur_ff.addr[1:0]),
    .cnt     (cur_ff.cnt),
    .bytes   (bytes_w)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dma_req              = (cur_ff.st == UBC_ST_RUN) && !cur_ff.stop
                                && (cur_ff.cnt != '0);
  assign dma_addr             = cur_ff.addr;
  assign dma_bytes            = bytes_w;
  assign take_w               = dma_req && dma_ack;
  assign channel_active_flag  = (cur_ff.st == UBC_ST_RUN);
  assign remaining_byte_count = cur_ff.cnt;
  assign rdata                = cur_ff.rdata;
  assign wr_ctrl_w            = bus.wr && (bus.addr == UBC_OFS_CTRL);

  // Received length, meaningful once the channel is idle
  always_comb begin
    if (cur_ff.len == 16'h0000) begin
      rx_len_w = UBC_FULL_LEN - cur_ff.cnt;
    end else begin
      rx_len_w = {1'b0, cur_ff.len} - cur_ff.cnt;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        UBC_OFS_CTRL: begin
          nxt_cur.stop = bus.wdata[UBC_CTRL_STOP];
        end
        UBC_OFS_LENGTH: begin
          if (cur_ff.st == UBC_ST_IDLE) begin
            nxt_cur.len = bus.wdata[15:0];
          end
        end
        UBC_OFS_ADDR: begin
          if (cur_ff.st == UBC_ST_IDLE) begin
            nxt_cur.addr = bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    case (cur_ff.st)
      UBC_ST_IDLE: begin
        if (wr_ctrl_w && bus.wdata[UBC_CTRL_START]) begin
          nxt_cur.cnt = (cur_ff.len == 16'h0000) ? UBC_FULL_LEN
                                                 : {1'b0, cur_ff.len};
          nxt_cur.st  = UBC_ST_RUN;
        end else if (wr_ctrl_w && bus.wdata[UBC_CTRL_RESUME]
                     && cur_ff.cnt != '0) begin
          nxt_cur.st = UBC_ST_RUN;
        end
      end
      UBC_ST_RUN: begin
        if (take_w) begin
          nxt_cur.cnt  = cur_ff.cnt - {14'h0000, bytes_w};
          nxt_cur.addr = cur_ff.addr + {29'h0000_0000, bytes_w};
          if (cur_ff.cnt == {14'h0000, bytes_w}) begin
            nxt_cur.st = UBC_ST_IDLE;
          end
        end
        // Freeze: active drops once no access is pending
        if (!dma_req) begin
          nxt_cur.st = UBC_ST_IDLE;
        end
      end
      default: begin
        nxt_cur.st = UBC_ST_IDLE;
      end
    endcase
    // Read data, one cycle after the strobe
    nxt_cur.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        UBC_OFS_CTRL:   nxt_cur.rdata = {30'h0, cur_ff.stop, 1'b0};
        UBC_OFS_LENGTH: nxt_cur.rdata = {16'h0000, cur_ff.len};
        UBC_OFS_ADDR:   nxt_cur.rdata = cur_ff.addr;
        UBC_OFS_STATUS: nxt_cur.rdata = {7'h00, channel_active_flag, 7'h00, cur_ff.cnt};
        UBC_OFS_RXLEN:  nxt_cur.rdata = {15'h0000, rx_len_w};
        default:        nxt_cur.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff.st    <= UBC_ST_IDLE;
      cur_ff.stop  <= 1'b0;
      cur_ff.len   <= UBC_LEN_RST;
      cur_ff.addr  <= UBC_ADDR_RST;
      cur_ff.cnt   <= '0;
      cur_ff.rdata <= 32'h0000_0000;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_count_step: assert property (
    take_w |=> cur_ff.cnt == $past(cur_ff.cnt) - {14'h0000, $past(bytes_w)})
    else $error("Count did not drop by the access width");

  a_count_hold: assert property (
    !take_w && !wr_ctrl_w |=> $stable(cur_ff.cnt))
    else $error("Count changed without an access or start");

  a_word_width: assert property (
    dma_req && cur_ff.addr[1:0] == 2'h0 && cur_ff.cnt >= 17'h00004
    |-> dma_bytes == 3'h4)
    else $error("Aligned access with room was not a word");

  a_no_overrun: assert property (
    dma_req |-> {14'h0000, dma_bytes} <= cur_ff.cnt
                && {1'b0, dma_bytes} <= 4'h4 - {2'h0, cur_ff.addr[1:0]})
    else $error("Access crosses buffer end or word boundary");

  a_last_idle: assert property (
    take_w && cur_ff.cnt == {14'h0000, bytes_w}
    |=> !channel_active_flag && cur_ff.cnt == '0)
    else $error("Channel stayed active after the last byte");

  a_rx_length: assert property (
    bus.rd && bus.addr == UBC_OFS_RXLEN && cur_ff.len == 16'h0000 && !channel_active_flag
    |=> rdata == {15'h0, UBC_FULL_LEN - $past(cur_ff.cnt)})
    else $error("Received length does not match count");

  // ----------------------------------------------------------------
  // Channel checks
  // ----------------------------------------------------------------
  a_start_load: assert property (
    cur_ff.st == UBC_ST_IDLE && wr_ctrl_w && bus.wdata[UBC_CTRL_START]
    |=> channel_active_flag && remaining_byte_count == ($past(cur_ff.len) == 16'h0000
        ? UBC_FULL_LEN : {1'b0, $past(cur_ff.len)}))
    else $error("Start did not load the buffer length");

  a_addr_step: assert property (
    take_w |=> dma_addr == $past(dma_addr) + {29'h0, $past(dma_bytes)})
    else $error("Address did not advance by the access width");

  a_width_legal: assert property (
    dma_req |-> dma_bytes == UBC_WORD_BYTES || dma_bytes == UBC_HALF_BYTES
                || dma_bytes == UBC_BYTE_BYTES)
    else $error("Access width is not one, two or four bytes");

  a_stop_freeze: assert property (
    cur_ff.stop && channel_active_flag
    |=> !channel_active_flag && $stable(cur_ff.cnt))
    else $error("Stopped channel did not freeze its count");

  a_len_locked: assert property (
    channel_active_flag |=> $stable(cur_ff.len))
    else $error("Buffer length changed while the channel ran");

  a_resume_keep: assert property (
    cur_ff.st == UBC_ST_IDLE && wr_ctrl_w && !bus.wdata[UBC_CTRL_START]
    |=> $stable(cur_ff.cnt))
    else $error("Resume or stop changed the remaining count");

  a_status_count: assert property (
    bus.rd && bus.addr == UBC_OFS_STATUS
    |=> rdata[16:0] == $past(cur_ff.cnt))
    else $error("Status read did not show the remaining count");

endmodule : ubc_counter
`default_nettype wire

// file: test/ubc_ahb_model.sv
// AHB slave side model: acknowledges address phases of the channel
// Assumes dma_req is a level that holds until acknowledged
`timescale 1ns/1ps
`default_nettype none
module ubc_ahb_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Channel side
  input  wire logic dma_req,
  input  wire logic slow,
  output logic      dma_ack
);
  // Prompt: ack every cycle; slow: every other cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_ack <= 1'b0;
    end else begin
      dma_ack <= dma_req & (~slow | ~dma_ack);
    end
  end
endmodule : ubc_ahb_model
`default_nettype wire

// file: test/tb.sv
// Testbench of the channel byte counter
// Assumes the register port and the AHB slave model beside the design
`timescale 1ns/1ps
`default_nettype none
module tb
  import ubc_pkg::*;
;
  logic        clk  = 1'b0;
  logic        nrst = 1'b0;
  logic        slow = 1'b0;
  ubc_bus_t    bus  = '0;
  logic [31:0] rdata, dma_addr, ea, v;
  logic [2:0]  dma_bytes, w;
  logic        dma_req, dma_ack, act;
  logic [16:0] cnt, ec;
  int          fail_count = 0;
  int          n_checks   = 0;

  always #5 clk = ~clk;

  ubc_counter dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_bytes(dma_bytes), .dma_ack(dma_ack),
    .channel_active_flag(act), .remaining_byte_count(cnt));
  ubc_ahb_model ahb (.clk(clk), .nrst(nrst), .dma_req(dma_req), .slow(slow), .dma_ack(dma_ack));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [2:0] wexp(logic [31:0] a, logic [16:0] c);
    if (a[1:0] == 2'h0 && c >= 17'h4) return 3'h4;
    if (!a[0] && c >= 17'h2) return 3'h2;
    return 3'h1;
  endfunction : wexp

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic wt_idle;
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      #1 if (act === 1'b0) return;
    end
    fail_count++;
    end_sim;
  endtask : wt_idle

  task automatic go(logic [31:0] a, logic [31:0] n);
    wr(UBC_OFS_LENGTH, n);
    wr(UBC_OFS_ADDR, a);
    ea = a;
    ec = (n == 32'h0) ? 17'h10000 : n[16:0];
    wr(UBC_OFS_CTRL, 32'h1);
  endtask : go

  // ----------------------------------------------------------------
  // Access monitor
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (nrst && dma_req && dma_ack) begin
      w = wexp(ea, ec);
      chk("dma_bytes", 32'(dma_bytes), 32'(w));
      chk("count", 32'(cnt), 32'(ec));
      chk("dma_addr", dma_addr, ea);
      ea = ea + 32'(w);
      ec = ec - 17'(w);
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(UBC_OFS_STATUS);
    chk("status reset", v, 32'h0);
    chk("req reset", 32'(dma_req), 32'h0);
    rd(8'h20);
    chk("unmapped", v, 32'h0);
    go(32'h1001, 32'h6);
    wt_idle;
    chk("count end", 32'(cnt), 32'h0);
    slow <= 1'b1;
    go(32'h2000, 32'h9);
    wt_idle;
    go(32'h3002, 32'h0);
    wr(UBC_OFS_LENGTH, 32'h5);
    wr(UBC_OFS_ADDR, 32'h0);
    chk("active run", 32'(act), 32'h1);
    repeat (20) @(posedge clk);
    wr(UBC_OFS_CTRL, 32'h2);
    wt_idle;
    rd(UBC_OFS_STATUS);
    chk("status frozen", v, {15'h0, ec});
    rd(UBC_OFS_CTRL);
    chk("stop readback", v, 32'h2);
    rd(UBC_OFS_LENGTH);
    chk("length kept", v, 32'h0);
    rd(UBC_OFS_RXLEN);
    chk("rx length", v, 32'(17'h10000 - ec));
    slow <= 1'b0;
    wr(UBC_OFS_CTRL, 32'h4);
    wt_idle;
    rd(UBC_OFS_RXLEN);
    chk("rx length end", v, 32'h10000);
    end_sim;
  end
endmodule : tb
`default_nettype wire
